/* hwc_pkg.sv */
// ********************************************************************
// Constants and carriers for the control register bank.
// ********************************************************************
package hwc_pkg;

  // Register word addresses on the serial link.
  localparam logic [6:0] ADDR_MODE_SUPPLY = 7'h01;
  localparam logic [6:0] ADDR_HARDWARE_CONTROL = 7'h02;
  localparam logic [6:0] ADDR_WATCHDOG_CONTROL = 7'h03;

  // Writable bits of each register; all other bits are reserved.
  localparam logic [15:0] MS_WRITE_MASK = 16'hc6a3;
  localparam logic [15:0] HW_WRITE_MASK = 16'h1e64;
  localparam logic [15:0] WD_WRITE_MASK = 16'h8077;

  // Reset values and the bits that survive each reset flavour.
  localparam logic [15:0] MS_RESET_VALUE = 16'h0000;
  localparam logic [15:0] MS_RESTART_KEEP = 16'h00a3;
  localparam logic [15:0] HW_RESET_VALUE = 16'h0000;
  localparam logic [15:0] HW_SOFT_KEEP = 16'h0200;
  localparam logic [15:0] HW_RESTART_KEEP = 16'h1240;
  localparam logic [15:0] WD_RESET_VALUE = 16'h0014;
  localparam logic [15:0] WD_RESTART_KEEP = 16'h0010;
  localparam logic [15:0] WD_RESTART_SET = 16'h0004;

  // Field positions.
  localparam int MS_MODE_LSB = 14;
  localparam int HW_THERMAL_SHUTDOWN_STAGE_TWO_WAIT_BIT = 12;
  localparam int HW_OV_SEL_BIT = 11;
  localparam int HW_SH_DIS_BIT = 10;
  localparam int HW_RST_DLY_BIT = 9;
  localparam int HW_SOFT_PIN_BIT = 6;
  localparam int HW_FAIL_OUTPUT_SW_ACTIVATE_BIT = 5;
  localparam int HW_STOP_WD_BIT = 2;
  localparam int WD_CHECKSUM_BIT = 15;
  localparam int WD_STOP_WD_BIT = 6;
  localparam int WD_TYPE_BIT = 5;
  localparam int WD_BUS_WAKE_BIT = 4;

  // Serial frame layout: write flag, address, data, trailing byte.
  localparam logic [5:0] FRAME_BITS = 6'd32;
  localparam logic [5:0] HEAD_BITS = 6'd8;
  localparam logic [5:0] DATA_END = 6'd24;

  // Timing figures and the cycle counts derived from them.
  localparam int CLK_KHZ = 125000;
  localparam int RST_DLY_LONG_MS = 10;
  localparam int RST_DLY_SHORT_MS = 2;
  localparam int THERMAL_SHUTDOWN_STAGE_TWO_WAIT_S = 1;
  localparam int RST_DLY_LONG_CYC = RST_DLY_LONG_MS * CLK_KHZ;
  localparam int RST_DLY_SHORT_CYC = RST_DLY_SHORT_MS * CLK_KHZ;
  localparam int THERMAL_SHUTDOWN_STAGE_TWO_WAIT_CYC = THERMAL_SHUTDOWN_STAGE_TWO_WAIT_S * CLK_KHZ * 1000;
  localparam logic [4:0] THERMAL_SHUTDOWN_STAGE_TWO_LONG_AFTER = 5'd16;

  // Device mode encoding.
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_SLEEP = 2'h1,
    MODE_STOP = 2'h2,
    MODE_SOFT_RESET = 2'h3
  } hwc_mode_e;

  // Serial pins as seen by the device.
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic mosi;
  } hwc_spi_s;

  // Idle pin levels after reset: link clock low, select high, data low.
  localparam hwc_spi_s SPI_IDLE = '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};

  // Hardware settings driven to the rest of the chip.
  typedef struct packed {
    logic thermal_stage2_wait_select;
    logic supply_overvoltage_threshold_select;
    logic sample_hold_disable;
    logic reset_delay_select;
    logic watchdog_type_select;
    logic checksum_bit;
    logic [2:0] watchdog_period_select;
  } hwc_cfg_s;

endpackage : hwc_pkg

/* hwc_sync2.sv */
`timescale 1ns/10ps
// ********************************************************************
// Two-stage synchroniser for pins from outside the clock domain.
// ********************************************************************
module hwc_sync2 #(
  parameter int W = 3,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= INIT;
      q <= INIT;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : hwc_sync2

/* hwc_regs.sv */
`timescale 1ns/10ps
//
// Contract
// - Mode register clears on power-on and soft reset; restart keeps bits 7,5,1,0.
// - A Sleep request written while in Stop leaves the mode unchanged.
// - Entering restart sets the mode field to Normal.
// - Mode codes: Normal 00, Sleep 01, Stop 10, soft reset 11.
// - A write frame returns the register contents held before that write.
// - Bit 12 lengthens the thermal wait 64 times after over 16 events.
// - Bit 11 selects the default or raised overvoltage threshold.
// - Bit 10 disables the gate driver sample-and-hold circuitry.
// - Bit 9 selects a 10 ms or 2 ms reset output delay.
// - Bit 6 clear pulls the reset output low during soft reset.
// - Bit 5 activates fail output only when the shared pin is fail output.
// - Clearing bit 5 does not release fail outputs raised by a failure.
// - Restart clears software fail activation; fail output then follows failures only.
// - Hardware control bit 2 disables the watchdog in Stop.
// - Hardware control bit 2 clears when the device goes from Stop to Normal.
// - Hardware control: power-on zero; soft keeps bit 9; restart keeps 12,9,6.
// - Reserved bits ignore writes and read as zero.
// - Watchdog control bit 15 is a host-written checksum bit.
// - Watchdog control bit 6 disables the watchdog in Stop.
// - Watchdog control bit 5 selects time-out or window watchdog.
// - Bit 4 lets a bus wake in Stop start the watchdog.
// - Period codes give 10,20,50,100,200,500 ms, 1 s, 10 s.
module hwc_regs
  import hwc_pkg::*;
#(
  parameter int RST_DLY_LONG = RST_DLY_LONG_CYC,
  parameter int RST_DLY_SHORT = RST_DLY_SHORT_CYC,
  parameter int THERMAL_SHUTDOWN_STAGE_TWO_WAIT = THERMAL_SHUTDOWN_STAGE_TWO_WAIT_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire hwc_spi_s spi_pins,
  output logic miso,
  output logic miso_oe,
  input wire logic [1:0] device_mode,
  input wire logic restart_entry,
  input wire logic thermal_stage2_event,
  input wire logic fail_pin_is_fail_output,
  input wire logic failure_active,
  input wire logic bus_wake_event,
  output logic [1:0] mode_request,
  output logic soft_reset_pulse,
  output logic reset_output_low,
  output logic fail_output,
  output logic thermal_wait_active,
  output logic watchdog_stop_off,
  output logic watchdog_bus_wake_start,
  output logic [13:0] watchdog_period_ms,
  output hwc_cfg_s hw_cfg
);

  // ******************************************************************
  // Reset release and pin synchronisation.
  // ******************************************************************

  logic [1:0] rst_sync_q;
  logic rst_n_int;
  hwc_spi_s spi_s;

  // Reset is asserted at once and released two clocks later.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n_int = rst_sync_q[1];

  // The copies start at the idle pin levels so that no false select follows reset.
  hwc_sync2 #(
    .W(3),
    .INIT(SPI_IDLE)
  ) u_pin_sync (
    .clock(clock),
    .rst_n(rst_n_int),
    .d(spi_pins),
    .q(spi_s)
  );

  // ******************************************************************
  // Serial frame engine.
  // ******************************************************************

  logic sck_prev_q;
  logic cs_prev_q;
  logic [5:0] bit_cnt_q;
  logic [31:0] in_sr_q;
  logic [15:0] out_sr_q;
  logic miso_q;
  logic miso_oe_q;
  logic [15:0] ms_q;
  logic [15:0] hw_q;
  logic [15:0] wd_q;
  logic [15:0] ms_d;
  logic [15:0] hw_d;
  logic [15:0] wd_d;

  // Edges of the sampled serial clock and select.
  wire sck_rise = spi_s.sck & ~sck_prev_q & ~spi_s.cs_n;
  wire sck_fall = ~spi_s.sck & sck_prev_q & ~spi_s.cs_n;
  wire frame_end = spi_s.cs_n & ~cs_prev_q;
  wire frame_full = (bit_cnt_q == FRAME_BITS);
  wire [6:0] head_addr = {in_sr_q[5:0], spi_s.mosi};
  wire load_reply = sck_rise & (bit_cnt_q == HEAD_BITS - 6'd1);

  // Frame fields once the whole frame has been shifted in.
  wire f_write = in_sr_q[31];
  wire [6:0] f_addr = in_sr_q[30:24];
  wire [15:0] f_data = in_sr_q[23:8];
  wire commit = frame_end & frame_full & f_write;
  wire wr_ms = commit & (f_addr == ADDR_MODE_SUPPLY);
  wire wr_hw = commit & (f_addr == ADDR_HARDWARE_CONTROL);
  wire wr_wd = commit & (f_addr == ADDR_WATCHDOG_CONTROL);

  // Read selection for the reply word; unmapped addresses answer zero.
  wire [15:0] reply_word =
    (head_addr == ADDR_MODE_SUPPLY) ? ms_q :
    (head_addr == ADDR_HARDWARE_CONTROL) ? hw_q :
    (head_addr == ADDR_WATCHDOG_CONTROL) ? wd_q : 16'h0000;

  // Shifting, bit counting and reply output.
  always_ff @(posedge clock or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      bit_cnt_q <= 6'h00;
      in_sr_q <= 32'h0000_0000;
      out_sr_q <= 16'h0000;
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0;
    end
    else
    begin
      sck_prev_q <= spi_s.sck;
      cs_prev_q <= spi_s.cs_n;
      miso_oe_q <= ~spi_s.cs_n;
      if (spi_s.cs_n)
      begin
        bit_cnt_q <= 6'h00;
        miso_q <= 1'b0;
      end
      else if (sck_rise)
      begin
        in_sr_q <= {in_sr_q[30:0], spi_s.mosi};
        if (!frame_full)
          bit_cnt_q <= bit_cnt_q + 6'd1;
      end
      if (load_reply)
        out_sr_q <= reply_word;
      else if (sck_fall && bit_cnt_q >= HEAD_BITS && bit_cnt_q < DATA_END)
      begin
        miso_q <= out_sr_q[15];
        out_sr_q <= {out_sr_q[14:0], 1'b0};
      end
      else if (sck_fall)
        miso_q <= 1'b0;
    end
  end

  // ******************************************************************
  // Register updates.
  // ******************************************************************

  logic [1:0] dev_mode_prev_q;
  wire [1:0] wr_mode = f_data[MS_MODE_LSB +: 2];
  wire soft_now = wr_ms & (wr_mode == MODE_SOFT_RESET);
  wire stop_sleep = (wr_mode == MODE_SLEEP) & (device_mode == MODE_STOP);
  wire stop_to_normal = (dev_mode_prev_q == MODE_STOP) & (device_mode == MODE_NORMAL);

  // Next values: restart over soft reset over host writes over device clears.
  always_comb
  begin
    ms_d = ms_q;
    hw_d = hw_q;
    wd_d = wd_q;
    if (stop_to_normal)
      hw_d[HW_STOP_WD_BIT] = 1'b0;
    if (wr_ms)
    begin
      ms_d = f_data & MS_WRITE_MASK;
      if (stop_sleep)
        ms_d[MS_MODE_LSB +: 2] = ms_q[MS_MODE_LSB +: 2];
    end
    if (wr_hw)
      hw_d = f_data & HW_WRITE_MASK;
    if (wr_wd)
      wd_d = f_data & WD_WRITE_MASK;
    if (restart_entry)
    begin
      ms_d = ms_q & MS_RESTART_KEEP;
      hw_d = hw_q & HW_RESTART_KEEP;
      wd_d = (wd_q & WD_RESTART_KEEP) | WD_RESTART_SET;
    end
    else if (soft_now)
    begin
      ms_d = MS_RESET_VALUE;
      hw_d = hw_q & HW_SOFT_KEEP;
      wd_d = WD_RESET_VALUE;
    end
  end

  // Register storage with power-on values.
  always_ff @(posedge clock or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      ms_q <= MS_RESET_VALUE;
      hw_q <= HW_RESET_VALUE;
      wd_q <= WD_RESET_VALUE;
      dev_mode_prev_q <= MODE_NORMAL;
    end
    else
    begin
      ms_q <= ms_d;
      hw_q <= hw_d;
      wd_q <= wd_d;
      dev_mode_prev_q <= device_mode;
    end
  end

  // ******************************************************************
  // Reset output and thermal wait timers.
  // ******************************************************************

  logic [20:0] rst_cnt_q;
  logic rst_low_q;
  logic soft_pulse_q;
  logic [33:0] tsd_cnt_q;
  logic [4:0] tsd_events_q;
  logic tsd_wait_q;
  wire [20:0] rst_load = hw_q[HW_RST_DLY_BIT] ? 21'(RST_DLY_SHORT) : 21'(RST_DLY_LONG);
  wire tsd_long = hw_q[HW_THERMAL_SHUTDOWN_STAGE_TWO_WAIT_BIT] & (tsd_events_q > THERMAL_SHUTDOWN_STAGE_TWO_LONG_AFTER);
  wire [33:0] tsd_base = 34'(THERMAL_SHUTDOWN_STAGE_TWO_WAIT);
  wire [33:0] tsd_load = tsd_long ? {tsd_base[27:0], 6'h00} : tsd_base;

  // Soft reset may pull the reset output low for the selected delay.
  always_ff @(posedge clock or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      rst_cnt_q <= 21'h000000;
      rst_low_q <= 1'b0;
      soft_pulse_q <= 1'b0;
    end
    else
    begin
      soft_pulse_q <= soft_now;
      if (soft_now && !hw_q[HW_SOFT_PIN_BIT])
      begin
        rst_low_q <= 1'b1;
        rst_cnt_q <= rst_load;
      end
      else if (rst_cnt_q > 21'h000001)
        rst_cnt_q <= rst_cnt_q - 21'd1;
      else
      begin
        rst_cnt_q <= 21'h000000;
        rst_low_q <= 1'b0;
      end
    end
  end

  // Each stage-two thermal event restarts the release wait.
  always_ff @(posedge clock or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      tsd_cnt_q <= 34'h0;
      tsd_events_q <= 5'h00;
      tsd_wait_q <= 1'b0;
    end
    else
    begin
      if (restart_entry)
        tsd_events_q <= 5'h00;
      else if (thermal_stage2_event && tsd_events_q != 5'h1f)
        tsd_events_q <= tsd_events_q + 5'd1;
      if (thermal_stage2_event)
      begin
        tsd_cnt_q <= tsd_load;
        tsd_wait_q <= 1'b1;
      end
      else if (tsd_cnt_q > 34'h1)
        tsd_cnt_q <= tsd_cnt_q - 34'd1;
      else
      begin
        tsd_cnt_q <= 34'h0;
        tsd_wait_q <= 1'b0;
      end
    end
  end

  // ******************************************************************
  // Derived outputs.
  // ******************************************************************

  logic fail_q;
  logic wd_stop_off_q;
  logic wd_wake_q;
  logic [13:0] period_q;
  logic [13:0] period_ms;
  hwc_cfg_s cfg_q;
  wire in_stop = (device_mode == MODE_STOP);

  // Period table from the three-bit code.
  always_comb
  begin
    case (wd_q[2:0])
      3'h0: period_ms = 14'd10;
      3'h1: period_ms = 14'd20;
      3'h2: period_ms = 14'd50;
      3'h3: period_ms = 14'd100;
      3'h4: period_ms = 14'd200;
      3'h5: period_ms = 14'd500;
      3'h6: period_ms = 14'd1000;
      default: period_ms = 14'd10000;
    endcase
  end

  // Registered fail, watchdog and configuration outputs.
  always_ff @(posedge clock or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      fail_q <= 1'b0;
      wd_stop_off_q <= 1'b0;
      wd_wake_q <= 1'b0;
      period_q <= 14'd200;
      cfg_q <= '0;
    end
    else
    begin
      fail_q <= (hw_q[HW_FAIL_OUTPUT_SW_ACTIVATE_BIT] & fail_pin_is_fail_output) | failure_active;
      wd_stop_off_q <= in_stop & (hw_q[HW_STOP_WD_BIT] | wd_q[WD_STOP_WD_BIT]);
      wd_wake_q <= in_stop & bus_wake_event & wd_q[WD_BUS_WAKE_BIT];
      period_q <= period_ms;
      cfg_q.thermal_stage2_wait_select <= hw_q[HW_THERMAL_SHUTDOWN_STAGE_TWO_WAIT_BIT];
      cfg_q.supply_overvoltage_threshold_select <= hw_q[HW_OV_SEL_BIT];
      cfg_q.sample_hold_disable <= hw_q[HW_SH_DIS_BIT];
      cfg_q.reset_delay_select <= hw_q[HW_RST_DLY_BIT];
      cfg_q.watchdog_type_select <= wd_q[WD_TYPE_BIT];
      cfg_q.checksum_bit <= wd_q[WD_CHECKSUM_BIT];
      cfg_q.watchdog_period_select <= wd_q[2:0];
    end
  end

  assign miso = miso_q;
  assign miso_oe = miso_oe_q;
  assign mode_request = ms_q[MS_MODE_LSB +: 2];
  assign soft_reset_pulse = soft_pulse_q;
  assign reset_output_low = rst_low_q;
  assign fail_output = fail_q;
  assign thermal_wait_active = tsd_wait_q;
  assign watchdog_stop_off = wd_stop_off_q;
  assign watchdog_bus_wake_start = wd_wake_q;
  assign watchdog_period_ms = period_q;
  assign hw_cfg = cfg_q;

  // ******************************************************************
  // Checks.
  // ******************************************************************

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n_int);

  chk_restart_mode_keep: assert property (restart_entry |=> ms_q == ($past(ms_q) & 16'h00a3))
    else $error("mode register restart value wrong");
  chk_stop_sleep_block: assert property (wr_ms & stop_sleep & !restart_entry
    |=> ms_q[15:14] == $past(ms_q[15:14]))
    else $error("sleep request from stop changed mode");
  chk_restart_normal: assert property (restart_entry |=> ms_q[15:14] == 2'h0)
    else $error("restart did not select normal mode");
  chk_reply_old_word: assert property (load_reply & (head_addr == ADDR_HARDWARE_CONTROL)
    |=> out_sr_q == $past(hw_q))
    else $error("reply word not the stored value");
  chk_hw_restart_keep: assert property (restart_entry |=> hw_q == ($past(hw_q) & 16'h1240))
    else $error("hardware register restart value wrong");
  chk_fo_restart_clear: assert property (restart_entry |=> !hw_q[5])
    else $error("software fail activation survived restart");
  chk_stop_wd_clear: assert property (stop_to_normal & !wr_hw |=> !hw_q[2])
    else $error("stop watchdog disable not cleared");
  chk_reserved_zero: assert property ((hw_q & 16'he19b) == 16'h0 && (wd_q & 16'h7f88) == 16'h0)
    else $error("reserved bit reads as one");
  chk_fail_held: assert property (failure_active |=> fail_output)
    else $error("failure did not hold fail output");
  chk_soft_pin_low: assert property (soft_now & !hw_q[6] |=> reset_output_low [*2])
    else $error("soft reset did not pull reset low");

endmodule : hwc_regs

/* hwc_spi_host.sv */
`timescale 1ns/10ps
// ********************************************************************
// Serial host model that frames 32-bit transfers for the register bank.
// ********************************************************************
module hwc_spi_host
  import hwc_pkg::*;
(
  input wire logic clock,
  output hwc_spi_s spi_pins,
  input wire logic miso
);
  // Half of the 80 ns link period, counted in system clock falls.
  localparam int HALF = 5;

  // The link clock stands low and the select stays high between frames.
  initial
  begin
    spi_pins = '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};
  end

  // One frame: write flag, address, data word and a zero trailing byte.
  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [15:0] wdata,
                      output logic [15:0] rdata);
    logic [31:0] frame;
    frame = {wr, addr, wdata, 8'h00};
    rdata = 16'h0000;
    spi_pins.cs_n = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      spi_pins.mosi = frame[i];
      repeat (HALF) @(negedge clock);
      spi_pins.sck = 1'b1;
      if (i <= 23 && i >= 8)
      begin
        rdata[i-8] = miso;
      end
      repeat (HALF) @(negedge clock);
      spi_pins.sck = 1'b0;
    end
    repeat (HALF) @(negedge clock);
    spi_pins.cs_n = 1'b1;
    // The deselected data line must not look like a held bit.
    spi_pins.mosi = ~spi_pins.mosi;
    repeat (8) @(negedge clock);
  endtask : xfer
endmodule : hwc_spi_host

/* hwc_regs_bench.sv */
`timescale 1ns/10ps
// ********************************************************************
// Self-checking bench for the control register bank.
// ********************************************************************
module hwc_regs_bench
  import hwc_pkg::*;
();
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] device_mode = 2'h0;
  logic restart_entry = 1'b0;
  logic thermal_stage2_event = 1'b0;
  logic fail_pin_is_fail_output = 1'b0;
  logic failure_active = 1'b0;
  logic bus_wake_event = 1'b0;
  hwc_spi_s spi_pins;
  logic miso, miso_oe, soft_reset_pulse, reset_output_low, fail_output;
  logic thermal_wait_active, watchdog_stop_off, watchdog_bus_wake_start;
  logic [1:0] mode_request;
  logic [13:0] watchdog_period_ms;
  hwc_cfg_s hw_cfg;
  logic [15:0] last;
  int miscompares = 0;
  int num_checks = 0;
  int rol_tot = 0;
  int twa_tot = 0;
  int wake_tot = 0;
  int sp_tot = 0;
  int t0;
  int period_tbl [8] = '{10, 20, 50, 100, 200, 500, 1000, 10000};
  logic [15:0] sr_hw [3] = '{16'h0200, 16'h0000, 16'h0040};
  int sr_lo [3] = '{10, 40, 0};

  // Free-running 125 MHz system clock.
  always #4 clock = ~clock;

  hwc_regs #(.RST_DLY_LONG(40), .RST_DLY_SHORT(10), .THERMAL_SHUTDOWN_STAGE_TWO_WAIT(20)) i_dut (
    .clock(clock), .rst_n(rst_n), .spi_pins(spi_pins), .miso(miso), .miso_oe(miso_oe),
    .device_mode(device_mode), .restart_entry(restart_entry),
    .thermal_stage2_event(thermal_stage2_event),
    .fail_pin_is_fail_output(fail_pin_is_fail_output), .failure_active(failure_active),
    .bus_wake_event(bus_wake_event), .mode_request(mode_request),
    .soft_reset_pulse(soft_reset_pulse), .reset_output_low(reset_output_low),
    .fail_output(fail_output), .thermal_wait_active(thermal_wait_active),
    .watchdog_stop_off(watchdog_stop_off), .watchdog_bus_wake_start(watchdog_bus_wake_start),
    .watchdog_period_ms(watchdog_period_ms), .hw_cfg(hw_cfg));

  hwc_spi_host i_host (.clock(clock), .spi_pins(spi_pins), .miso(miso));

  // Running totals of cycles spent high by timed outputs, and of wake starts.
  always @(posedge clock)
  begin
    rol_tot <= rol_tot + int'(reset_output_low);
    twa_tot <= twa_tot + int'(thermal_wait_active);
    wake_tot <= wake_tot + int'(watchdog_bus_wake_start);
    sp_tot <= sp_tot + int'(soft_reset_pulse);
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    i_host.xfer(1'b1, a, d, last);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [15:0] exp, input string what);
    logic [15:0] v;
    i_host.xfer(1'b0, a, 16'h0000, v);
    check(v, exp, what);
  endtask : rd

  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask : wait_n

  // One-cycle pulse on an event input, launched and ended on falling edges.
  task automatic pulse(ref logic s);
    s = 1'b1;
    wait_n(1);
    s = 1'b0;
    wait_n(3);
  endtask : pulse

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // Cuts a hung run short well after the tests should have ended.
  initial
  begin
    repeat (40000) @(posedge clock);
    miscompares++;
    stop_test();
  end

  // Test sequence: each group ends with one progress line.
  initial
  begin
    wait_n(20);
    rst_n = 1'b1;
    wait_n(6);
    rd(7'h01, 16'h0000, "ms por");
    rd(7'h02, 16'h0000, "hw por");
    rd(7'h03, 16'h0014, "wd por");
    check({2'h0, watchdog_period_ms}, 16'd200, "period por");
    $display("test power_on done");
    wr(7'h02, 16'hffff);
    check(last, 16'h0000, "hw prior");
    wr(7'h03, 16'hffff);
    check(last, 16'h0014, "wd prior");
    wr(7'h01, 16'h7fff);
    check({14'h0, mode_request}, 16'h0001, "sleep code");
    rd(7'h01, 16'h46a3, "ms mask");
    rd(7'h02, 16'h1e64, "hw mask");
    rd(7'h03, 16'h8077, "wd mask");
    rd(7'h7f, 16'h0000, "unmapped");
    check({7'h0, hw_cfg}, 16'h01ff, "cfg");
    check({15'h0, miso_oe}, 16'h0000, "oe idle");
    $display("test access done");
    check({15'h0, fail_output}, 16'h0000, "fo pin");
    fail_pin_is_fail_output = 1'b1;
    wait_n(3);
    check({15'h0, fail_output}, 16'h0001, "fo sw");
    failure_active = 1'b1;
    wr(7'h02, 16'h1e44);
    check({15'h0, fail_output}, 16'h0001, "fo fail");
    failure_active = 1'b0;
    wait_n(3);
    check({15'h0, fail_output}, 16'h0000, "fo off");
    wr(7'h02, 16'h1e64);
    pulse(restart_entry);
    check({15'h0, fail_output}, 16'h0000, "fo restart");
    rd(7'h01, 16'h00a3, "ms restart");
    rd(7'h02, 16'h1240, "hw restart");
    $display("test restart done");
    for (int c = 0; c < 8; c++)
    begin
      wr(7'h03, {13'h0, c[2:0]});
      check({2'h0, watchdog_period_ms}, 16'(period_tbl[c]), "period");
    end
    $display("test period done");
    wr(7'h01, 16'h8000);
    check({14'h0, mode_request}, 16'h0002, "stop code");
    device_mode = MODE_STOP;
    wr(7'h01, 16'h4000);
    check({14'h0, mode_request}, 16'h0002, "no sleep");
    check({15'h0, watchdog_stop_off}, 16'h0000, "wd on");
    wr(7'h02, 16'h0004);
    check({15'h0, watchdog_stop_off}, 16'h0001, "wd off hw");
    device_mode = MODE_NORMAL;
    wait_n(3);
    rd(7'h02, 16'h0000, "stop clear");
    device_mode = MODE_STOP;
    wr(7'h03, 16'h0050);
    check({15'h0, watchdog_stop_off}, 16'h0001, "wd off wd");
    t0 = wake_tot;
    pulse(bus_wake_event);
    check(16'(wake_tot - t0), 16'h0001, "wake start");
    wr(7'h03, 16'h0000);
    check({15'h0, watchdog_stop_off}, 16'h0000, "wd on wd");
    t0 = wake_tot;
    pulse(bus_wake_event);
    check(16'(wake_tot - t0), 16'h0000, "no wake start");
    device_mode = MODE_NORMAL;
    $display("test stop done");
    t0 = twa_tot;
    pulse(thermal_stage2_event);
    wait_n(60);
    check({15'h0, twa_tot - t0 >= 20 && twa_tot - t0 < 24}, 16'h0001, "short wait");
    wr(7'h02, 16'h1000);
    for (int e = 0; e < 17; e++)
    begin
      pulse(thermal_stage2_event);
      wait_n(26);
    end
    wait_n(1400);
    t0 = twa_tot;
    pulse(thermal_stage2_event);
    wait_n(1400);
    check({15'h0, twa_tot - t0 >= 1280 && twa_tot - t0 < 1290}, 16'h0001, "long wait");
    $display("test thermal done");
    for (int k = 0; k < 3; k++)
    begin
      wr(7'h02, sr_hw[k]);
      t0 = rol_tot;
      wr(7'h01, 16'hc000);
      wait_n(60);
      check({15'h0, rol_tot - t0 >= sr_lo[k] && rol_tot - t0 <= sr_lo[k] + 2}, 16'h0001,
            "reset low");
      rd(7'h02, sr_hw[k] & 16'h0200, "hw soft");
    end
    rd(7'h01, 16'h0000, "ms soft");
    check(16'(sp_tot), 16'h0003, "soft pulses");
    $display("test soft_reset done");
    stop_test();
  end
endmodule : hwc_regs_bench
